// File: inc/sfpi_pkg.sv
// Constants and types for the serial flash pin interface
// Behaviour
// RULE_01 - Deselect: standby, serial output high impedance
// RULE_02 - Deselected device ignores serial input
// RULE_03 - Select falling starts, rising ends operation
// RULE_04 - Standby waits for self-timed operation end
// RULE_05 - Serial input sampled on clock rising edge
// RULE_06 - Serial output shifted on clock falling edge
// RULE_07 - Host sends everything on serial input
// RULE_08 - Protect pin blocks protected sector writes
// RULE_09 - Protect pin freezes sector protection register
// RULE_10 - Blocked command ignored, idle after deselect
// RULE_11 - Protection enable and lockdown always accepted
// RULE_12 - Protect input reads deasserted when floating
// RULE_13 - Reset pin low aborts, forces idle
// RULE_14 - Held in reset while pin low
// RULE_15 - Own power-on reset, no pin sequencing
// RULE_16 - Works in clock modes 0 and 3
// RULE_17 - Fixed page count, binary or extended size
// RULE_18 - Program and erase timed internally
// RULE_19 - First byte opcode, then address bytes
// RULE_20 - All bytes most significant bit first
// RULE_21 - Output high impedance unless returning data
package sfpi_pkg;

    // ****************************************
    // Sizes
    // ****************************************
    localparam int SFPI_BYTE_W = 8;
    localparam int SFPI_ADDR_BYTES = 3;
    localparam int SFPI_PAGE_COUNT = 1024;
    localparam int SFPI_PAGE_BIN = 256;
    localparam int SFPI_PAGE_EXT = 264;
    localparam int SFPI_PAGE_W = 10;
    localparam int SFPI_BADDR_W = 9;
    localparam int SFPI_FIFO_DEPTH = 32;
    localparam logic [7:0] SFPI_TX_IDLE = 8'hff;

    // ****************************************
    // Timing
    // ****************************************
    localparam int SFPI_CLK_MHZ = 125;
    localparam int SFPI_PROG_TIME_US = 100;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        SFPI_ST_IDLE = 2'b00,
        SFPI_ST_OPC = 2'b01,
        SFPI_ST_ADDR = 2'b10,
        SFPI_ST_DATA = 2'b11
    } sfpi_state_t;

    typedef enum logic [1:0] {
        SFPI_KIND_OTHER = 2'b00,
        SFPI_KIND_PGM = 2'b01,
        SFPI_KIND_SPR = 2'b10,
        SFPI_KIND_EXEMPT = 2'b11
    } sfpi_kind_t;

endpackage : sfpi_pkg

// File: hdl/sfpi_fifo.sv
// Received-byte FIFO with valid/ready on both sides
`timescale 1ns/10ps
module sfpi_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW:0] wr_ptr_r;
    logic [AW:0] rd_ptr_r;
    logic push;
    logic pop;

    // ****************************************
    // Full and empty
    // ****************************************
    assign in_ready_out = (wr_ptr_r ^ rd_ptr_r) != {1'b1, {AW{1'b0}}};
    assign out_valid_out = wr_ptr_r != rd_ptr_r;
    assign push = in_valid_in & in_ready_out;
    assign pop = out_valid_out & out_ready_in;
    assign out_data_out = mem_r[rd_ptr_r[AW-1:0]];

    // Storage write
    always_ff @(posedge clk_in)
    begin
        if (push)
        begin
            mem_r[wr_ptr_r[AW-1:0]] <= in_data_in;
        end
    end

    // Pointers
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
        end
    end

endmodule : sfpi_fifo

// File: hdl/sfpi_top.sv
// Serial flash pin interface: framing, shifting, protect gating, reset
`timescale 1ns/10ps
module sfpi_top
    import sfpi_pkg::*;
#(
    parameter int PROG_TIME_US = SFPI_PROG_TIME_US,
    parameter int PROG_CYCLES = PROG_TIME_US * SFPI_CLK_MHZ,
    parameter int FIFO_DEPTH = SFPI_FIFO_DEPTH
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic cs_n_in,
    input wire logic sck_in,
    input wire logic si_in,
    input wire logic wp_n_in,
    input wire logic rst_n_in,
    output logic so_out,
    output logic so_oe_n_out,
    output logic [7:0] opcode_out,
    output logic opcode_valid_out,
    output logic [SFPI_PAGE_W-1:0] page_addr_out,
    output logic [SFPI_BADDR_W-1:0] byte_addr_out,
    output logic [SFPI_BADDR_W-1:0] page_size_out,
    input wire logic page_bin_in,
    input wire sfpi_kind_t cmd_kind_in,
    input wire logic sect_prot_in,
    output logic exec_out,
    output logic blocked_out,
    output logic busy_out,
    output logic standby_out,
    output logic [7:0] rx_data_out,
    output logic rx_valid_out,
    input wire logic rx_ready_in,
    output logic rx_drop_out,
    input wire logic tx_en_in,
    input wire logic [7:0] tx_data_in,
    input wire logic tx_valid_in,
    output logic tx_ready_out
);

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [1:0] cs_s_r;
    logic [2:0] sck_s_r;
    logic [1:0] si_s_r;
    logic [1:0] wp_s_r;
    logic [1:0] rp_s_r;
    logic cs_d_r;

    // Two flops per pin, a third on clock and select for edges; protect and reset idle high as if pulled up
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in) // see RULE_15
        begin
            cs_s_r <= 2'h3;
            sck_s_r <= 3'h0;
            si_s_r <= 2'h0;
            wp_s_r <= 2'h3; // see RULE_12
            rp_s_r <= 2'h3;
            cs_d_r <= 1'b1;
        end
        else
        begin
            cs_s_r <= {cs_s_r[0], cs_n_in};
            sck_s_r <= {sck_s_r[1:0], sck_in};
            si_s_r <= {si_s_r[0], si_in};
            wp_s_r <= {wp_s_r[0], wp_n_in};
            rp_s_r <= {rp_s_r[0], rst_n_in};
            cs_d_r <= cs_s_r[1];
        end
    end

    // ****************************************
    // Events
    // ****************************************
    logic sel;
    logic cs_fall;
    logic cs_rise;
    logic sck_rise;
    logic sck_fall;
    logic soft_rst;
    logic wp_on;
    logic byte_done;
    logic end_evt;
    logic [7:0] byte_nxt;
    sfpi_state_t state_r;
    logic [2:0] bit_cnt_r;
    logic [7:0] sh_r;

    // Both clock modes: only edges matter, never idle level; see RULE_16
    assign sel = ~cs_s_r[1];
    assign cs_fall = ~cs_s_r[1] & cs_d_r;
    assign cs_rise = cs_s_r[1] & ~cs_d_r;
    assign sck_rise = sck_s_r[1] & ~sck_s_r[2];
    assign sck_fall = ~sck_s_r[1] & sck_s_r[2];
    assign soft_rst = sys_rst_in | ~rp_s_r[1]; // see RULE_14
    assign wp_on = ~wp_s_r[1];
    assign byte_done = sck_rise & sel & ~cs_fall & (bit_cnt_r == 3'h7);
    assign byte_nxt = {sh_r[6:0], si_s_r[1]}; // see RULE_20
    assign end_evt = cs_rise & ((state_r == SFPI_ST_ADDR) | (state_r == SFPI_ST_DATA));

    // ****************************************
    // Frame state
    // ****************************************
    logic [1:0] addr_cnt_r;

    // Select edges bound the operation; reset pin forces idle
    always_ff @(posedge clk_in)
    begin
        if (soft_rst) // see RULE_13
        begin
            state_r <= SFPI_ST_IDLE;
            addr_cnt_r <= 2'h0;
        end
        else if (cs_rise) // see RULE_03
        begin
            state_r <= SFPI_ST_IDLE; // see RULE_10
        end
        else if (cs_fall)
        begin
            state_r <= SFPI_ST_OPC;
            addr_cnt_r <= 2'h0;
        end
        else if (byte_done)
        begin
            unique case (state_r)
                SFPI_ST_OPC: state_r <= SFPI_ST_ADDR; // see RULE_19
                SFPI_ST_ADDR:
                begin
                    addr_cnt_r <= addr_cnt_r + 2'h1;
                    if (addr_cnt_r == 2'(SFPI_ADDR_BYTES - 1))
                    begin
                        state_r <= SFPI_ST_DATA;
                    end
                end
                SFPI_ST_DATA: state_r <= SFPI_ST_DATA;
                SFPI_ST_IDLE: state_r <= SFPI_ST_IDLE;
            endcase
        end
    end

    // ****************************************
    // Input shifter
    // ****************************************
    // Bits taken only while selected, on clock rising edges
    always_ff @(posedge clk_in)
    begin
        if (soft_rst || !sel || cs_fall) // see RULE_02
        begin
            bit_cnt_r <= 3'h0;
            sh_r <= 8'h0;
        end
        else if (sck_rise) // see RULE_05
        begin
            bit_cnt_r <= bit_cnt_r + 3'h1;
            sh_r <= byte_nxt; // see RULE_07
        end
    end

    // ****************************************
    // Opcode and address capture
    // ****************************************
    logic [7:0] opcode_r;
    logic opc_valid_r;
    logic [23:0] addr_r;

    // First byte is the opcode, then address bytes high first
    always_ff @(posedge clk_in)
    begin
        if (soft_rst)
        begin
            opcode_r <= 8'h0;
            opc_valid_r <= 1'b0;
            addr_r <= 24'h0;
        end
        else
        begin
            opc_valid_r <= byte_done & (state_r == SFPI_ST_OPC);
            if (byte_done && state_r == SFPI_ST_OPC) // see RULE_19
            begin
                opcode_r <= byte_nxt;
            end
            if (byte_done && state_r == SFPI_ST_ADDR)
            begin
                addr_r <= {addr_r[15:0], byte_nxt};
            end
        end
    end

    assign opcode_out = opcode_r;
    assign opcode_valid_out = opc_valid_r;

    // ****************************************
    // Page organisation
    // ****************************************
    logic [SFPI_PAGE_W-1:0] page_r;
    logic [SFPI_BADDR_W-1:0] baddr_r;
    logic [SFPI_BADDR_W-1:0] psize_r;

    // Fixed page count; address split follows page size; see RULE_17
    always_ff @(posedge clk_in)
    begin
        if (soft_rst)
        begin
            page_r <= '0;
            baddr_r <= '0;
            psize_r <= SFPI_BADDR_W'(SFPI_PAGE_EXT);
        end
        else if (page_bin_in)
        begin
            page_r <= addr_r[SFPI_PAGE_W+7:8];
            baddr_r <= {1'b0, addr_r[7:0]};
            psize_r <= SFPI_BADDR_W'(SFPI_PAGE_BIN);
        end
        else
        begin
            page_r <= addr_r[SFPI_PAGE_W+8:9];
            baddr_r <= addr_r[8:0];
            psize_r <= SFPI_BADDR_W'(SFPI_PAGE_EXT);
        end
    end

    assign page_addr_out = page_r;
    assign byte_addr_out = baddr_r;
    assign page_size_out = psize_r;

    // ****************************************
    // Protect gating
    // ****************************************
    logic blocked;
    logic exec_r;
    logic blocked_r;

    // Protect pin blocks protected writes and register changes
    assign blocked = wp_on & (((cmd_kind_in == SFPI_KIND_PGM) & sect_prot_in) // see RULE_08
        | (cmd_kind_in == SFPI_KIND_SPR)); // see RULE_09

    // Decision taken when select rises; exempt kinds always run
    always_ff @(posedge clk_in)
    begin
        if (soft_rst)
        begin
            exec_r <= 1'b0;
            blocked_r <= 1'b0;
        end
        else
        begin
            exec_r <= end_evt & ~blocked; // see RULE_11
            blocked_r <= end_evt & blocked; // see RULE_10
        end
    end

    assign exec_out = exec_r;
    assign blocked_out = blocked_r;

    // ****************************************
    // Self-timed operation
    // ****************************************
    logic [31:0] busy_cnt_r;

    // Internal timer; pin reset aborts it
    always_ff @(posedge clk_in)
    begin
        if (soft_rst) // see RULE_13
        begin
            busy_cnt_r <= 32'h0;
        end
        else if (end_evt && !blocked && cmd_kind_in != SFPI_KIND_OTHER) // see RULE_18
        begin
            busy_cnt_r <= 32'(PROG_CYCLES);
        end
        else if (busy_cnt_r != 32'h0)
        begin
            busy_cnt_r <= busy_cnt_r - 32'h1;
        end
    end

    assign busy_out = busy_cnt_r != 32'h0;
    // Select rise cycle is not standby yet: timer loads one edge later
    assign standby_out = cs_s_r[1] & cs_d_r & ~busy_out; // see RULE_04

    // ****************************************
    // Received data path
    // ****************************************
    logic push_v;
    logic push_rdy;
    logic drop_r;

    assign push_v = byte_done & (state_r == SFPI_ST_DATA);

    sfpi_fifo #(
        .WIDTH(SFPI_BYTE_W),
        .DEPTH(FIFO_DEPTH)
    ) sfpi_fifo_i (
        .clk_in(clk_in),
        .rst_in(soft_rst),
        .in_valid_in(push_v),
        .in_ready_out(push_rdy),
        .in_data_in(byte_nxt),
        .out_valid_out(rx_valid_out),
        .out_ready_in(rx_ready_in),
        .out_data_out(rx_data_out)
    );

    // Byte lost when FIFO full
    always_ff @(posedge clk_in)
    begin
        if (soft_rst)
        begin
            drop_r <= 1'b0;
        end
        else
        begin
            drop_r <= push_v & ~push_rdy;
        end
    end

    assign rx_drop_out = drop_r;

    // ****************************************
    // Output shifter
    // ****************************************
    logic [7:0] tx_sh_r;
    logic tx_on_r;
    logic so_r;
    logic so_oe_n_r;

    assign tx_ready_out = byte_done & tx_en_in;

    // Load at byte boundary, shift out on falling edges
    always_ff @(posedge clk_in)
    begin
        if (soft_rst || !sel || cs_fall)
        begin
            tx_sh_r <= SFPI_TX_IDLE;
            tx_on_r <= 1'b0;
            so_r <= 1'b0;
            so_oe_n_r <= 1'b1; // see RULE_01
        end
        else if (byte_done)
        begin
            tx_on_r <= tx_en_in;
            tx_sh_r <= tx_valid_in ? tx_data_in : SFPI_TX_IDLE;
            if (!tx_en_in)
            begin
                so_oe_n_r <= 1'b1; // see RULE_21
            end
        end
        else if (sck_fall && tx_on_r) // see RULE_06
        begin
            so_r <= tx_sh_r[7]; // see RULE_20
            tx_sh_r <= {tx_sh_r[6:0], 1'b0};
            so_oe_n_r <= 1'b0;
        end
    end

    assign so_out = so_r;
    assign so_oe_n_out = so_oe_n_r;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    so_hiz_a: assert property (cs_s_r[1] |=> so_oe_n_out) // see RULE_01
        else $error("Serial output driven while deselected");
    desel_hold_a: assert property (cs_s_r[1] && cs_d_r |=> $stable(sh_r)) // see RULE_02
        else $error("Input shifter moved while deselected");
    frame_start_a: assert property (cs_fall && !soft_rst |=> state_r == SFPI_ST_OPC) // see RULE_03
        else $error("Select fall did not start a frame");
    standby_wait_a: assert property ((busy_out || end_evt) |-> !standby_out) // see RULE_04
        else $error("Standby entered while busy");
    opcode_take_a: assert property (byte_done && state_r == SFPI_ST_OPC && !soft_rst
        |=> opc_valid_r && opcode_r == $past(byte_nxt)) // see RULE_05
        else $error("Opcode not captured on rising edge");
    so_fall_a: assert property (!soft_rst && !$past(soft_rst) && sel && !$past(cs_fall)
        && $changed(so_out)
        |-> $past(sck_fall)) // see RULE_06
        else $error("Serial output moved off a falling edge");
    wp_pgm_a: assert property (end_evt && !soft_rst && wp_on && sect_prot_in
        && cmd_kind_in == SFPI_KIND_PGM |=> blocked_out && !exec_out ##1 !busy_out) // see RULE_08
        else $error("Protected program not blocked");
    wp_spr_a: assert property (end_evt && !soft_rst && wp_on && cmd_kind_in == SFPI_KIND_SPR
        |=> blocked_out && !exec_out) // see RULE_09
        else $error("Protection register change not blocked");
    exempt_run_a: assert property (end_evt && !soft_rst && cmd_kind_in == SFPI_KIND_EXEMPT
        |=> exec_out ##1 busy_out) // see RULE_11
        else $error("Exempt command refused");
    pin_rst_a: assert property (!rp_s_r[1] |=> state_r == SFPI_ST_IDLE && !busy_out) // see RULE_13
        else $error("Reset pin did not force idle");

    frame_data_c: cover property (push_v && push_rdy);
    blocked_c: cover property (blocked_out);
    read_c: cover property (!so_oe_n_out ##[1:64] so_oe_n_out);

endmodule : sfpi_top

// File: tb/sfpi_host_model.sv
// Host-side serial master model: select, serial clock, serial input
`timescale 1ns/10ps
module sfpi_host_model (
    input wire logic clk_in,
    input wire logic so_in,
    output logic cs_n_out,
    output logic sck_out,
    output logic si_out
);
    initial
    begin
        cs_n_out = 1'b1;
        sck_out = 1'b0;
        si_out = 1'b0;
    end

    // Released input line keeps changing while deselected
    always @(posedge clk_in)
    begin
        if (cs_n_out) si_out <= ~si_out;
    end

    // Park the clock at the mode's idle level, then drop select
    task automatic start_frame(input logic m3);
        @(posedge clk_in);
        sck_out <= m3;
        repeat (4) @(posedge clk_in);
        cs_n_out <= 1'b0;
        repeat (4) @(posedge clk_in);
    endtask : start_frame

    // One byte each way, top bit first; returned bit taken late in the high phase
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--)
        begin
            @(posedge clk_in);
            sck_out <= 1'b0;
            si_out <= tx[i];
            repeat (4) @(posedge clk_in);
            sck_out <= 1'b1;
            repeat (3) @(posedge clk_in);
            rx[i] = so_in;
        end
        repeat (4) @(posedge clk_in);
    endtask : xfer

    // Return the clock to idle, then raise select
    task automatic end_frame(input logic m3);
        @(posedge clk_in);
        sck_out <= m3;
        repeat (4) @(posedge clk_in);
        cs_n_out <= 1'b1;
        repeat (8) @(posedge clk_in);
    endtask : end_frame
endmodule : sfpi_host_model

// File: tb/tb_sfpi_top.sv
// Self-checking bench for the serial flash pin interface
`timescale 1ns/10ps
module tb_sfpi_top;
    import sfpi_pkg::*;
    localparam int PROG_CYC = 20;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic wp_n_in = 1'b1;
    logic rst_n_in = 1'b1;
    logic page_bin_in = 1'b0;
    sfpi_kind_t cmd_kind_in = SFPI_KIND_OTHER;
    logic sect_prot_in = 1'b0;
    logic rx_ready_in = 1'b0;
    logic tx_en_in = 1'b0;
    logic [7:0] tx_data_in = 8'h00;
    logic tx_valid_in = 1'b0;
    logic cs_n_w, sck_w, si_w, so_out, so_oe_n_out, opcode_valid_out;
    logic exec_out, blocked_out, busy_out, standby_out, rx_valid_out, rx_drop_out, tx_ready_out;
    logic [7:0] opcode_out, rx_data_out, b, r;
    logic [SFPI_PAGE_W-1:0] page_addr_out;
    logic [SFPI_BADDR_W-1:0] byte_addr_out, page_size_out;
    logic [31:0] seed = 32'h27a77e8b;
    logic hold_rx = 1'b0;
    int failures = 0;
    int cmp_count = 0;
    int cyc = 0;
    int busy_cnt = 0;
    int drop_cnt = 0;
    int tx_cnt = 0;
    logic [7:0] opq[$];
    logic [7:0] rxq[$];
    logic [20:0] evq[$];

    // ****************************************
    // Design, far side and clock
    // ****************************************
    sfpi_top #(.PROG_CYCLES(PROG_CYC)) sfpi_top_i (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .cs_n_in(cs_n_w), .sck_in(sck_w),
        .si_in(si_w), .wp_n_in(wp_n_in), .rst_n_in(rst_n_in), .so_out(so_out),
        .so_oe_n_out(so_oe_n_out), .opcode_out(opcode_out),
        .opcode_valid_out(opcode_valid_out), .page_addr_out(page_addr_out),
        .byte_addr_out(byte_addr_out), .page_size_out(page_size_out),
        .page_bin_in(page_bin_in), .cmd_kind_in(cmd_kind_in), .sect_prot_in(sect_prot_in),
        .exec_out(exec_out), .blocked_out(blocked_out), .busy_out(busy_out),
        .standby_out(standby_out), .rx_data_out(rx_data_out), .rx_valid_out(rx_valid_out),
        .rx_ready_in(rx_ready_in), .rx_drop_out(rx_drop_out), .tx_en_in(tx_en_in),
        .tx_data_in(tx_data_in), .tx_valid_in(tx_valid_in), .tx_ready_out(tx_ready_out)
    );
    // Released output shows the inverse of its last value to the host
    sfpi_host_model host_i (
        .clk_in(clk_in), .so_in(so_oe_n_out ? ~so_out : so_out), .cs_n_out(cs_n_w),
        .sck_out(sck_w), .si_out(si_w)
    );
    initial
    begin
        forever #4 clk_in = ~clk_in;
    end

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic finish_test();
        $display("failures %0d comparisons %0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : finish_test

    // Full frame: opcode, three address bytes, nd data bytes; notes every result
    task automatic frame(input int nd, input logic [1:0] k, input logic prot, input logic m3);
        logic [7:0] ob, rb;
        logic [23:0] a;
        logic blk;
        blk = !wp_n_in && ((k == 2'd1 && prot) || k == 2'd2);
        a = 24'(rnd());
        ob = 8'(rnd());
        @(posedge clk_in);
        cmd_kind_in <= sfpi_kind_t'(k);
        sect_prot_in <= prot;
        host_i.start_frame(m3);
        opq.push_back(ob);
        host_i.xfer(ob, rb);
        for (int i = 2; i >= 0; i--) host_i.xfer(a[8*i +: 8], rb);
        for (int i = 0; i < nd; i++)
        begin
            ob = 8'(rnd());
            if (!hold_rx || i < SFPI_FIFO_DEPTH) rxq.push_back(ob);
            host_i.xfer(ob, rb);
            if (tx_en_in) chk("so_byte", tx_valid_in ? tx_data_in : 8'hff, rb);
            chk("oe_sel", 24'(!tx_en_in), 24'(so_oe_n_out));
        end
        evq.push_back({blk, !blk, page_bin_in ? {a[17:8], 1'b0, a[7:0]} : a[18:0]});
        host_i.end_frame(m3);
        chk("oe_desel", 24'h1, 24'(so_oe_n_out));
        for (int n = 0; n < 200 && standby_out !== 1'b1; n++) @(posedge clk_in);
        chk("busy_seen", 24'(!blk && k != 2'd0), 24'(busy_cnt != 0));
        busy_cnt = 0;
    endtask : frame

    // ****************************************
    // Result watcher: each result takes the oldest note of its kind
    // ****************************************
    always @(posedge clk_in)
    begin
        cyc++;
        rx_ready_in <= hold_rx ? 1'b0 : 1'(rnd() >> 31);
        if (opcode_valid_out === 1'b1)
            chk("opcode", opq.size() ? opq.pop_front() : 24'hbad, opcode_out);
        if (rx_valid_out === 1'b1 && rx_ready_in)
            chk("rx_data", rxq.size() ? rxq.pop_front() : 24'hbad, rx_data_out);
        if (exec_out === 1'b1 || blocked_out === 1'b1)
            chk("event", evq.size() ? evq.pop_front() : 24'hbad,
                {blocked_out, exec_out, page_addr_out, byte_addr_out});
        if (busy_out === 1'b1)
        begin
            busy_cnt++;
            chk("standby_busy", 24'h0, 24'(standby_out));
        end
        if (rx_drop_out === 1'b1) drop_cnt++;
        if (tx_ready_out === 1'b1) tx_cnt++;
        if (cyc == 60000)
        begin
            failures++;
            finish_test();
        end
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        repeat (2) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        chk("size_ext", 24'h108, 24'(page_size_out));
        chk("oe_idle", 24'h1, 24'(so_oe_n_out));
        frame(2, 2'd1, 1'b1, 1'b0);
        page_bin_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        chk("size_bin", 24'h100, 24'(page_size_out));
        frame(1, 2'd0, 1'b0, 1'b1);
        // Every command kind with protect asserted
        wp_n_in <= 1'b0;
        for (int k = 0; k < 4; k++) frame(0, k[1:0], 1'b1, k[0]);
        frame(1, 2'd1, 1'b0, 1'b0);
        wp_n_in <= 1'b1;
        // Read data out, then a byte with nothing offered
        tx_en_in <= 1'b1;
        tx_valid_in <= 1'b1;
        tx_data_in <= 8'(rnd());
        frame(2, 2'd0, 1'b0, 1'b1);
        tx_valid_in <= 1'b0;
        frame(1, 2'd0, 1'b0, 1'b0);
        tx_en_in <= 1'b0;
        chk("tx_taken", 24'd11, 24'(tx_cnt));
        // Buffer filled past full while the reader stalls, then drained
        hold_rx = 1'b1;
        frame(SFPI_FIFO_DEPTH + 2, 2'd0, 1'b0, 1'b0);
        chk("drops", 24'h2, 24'(drop_cnt));
        hold_rx = 1'b0;
        for (int n = 0; n < 400 && rxq.size() != 0; n++) @(posedge clk_in);
        chk("drained", 24'h0, 24'(rxq.size()));
        // Reset pin in mid-frame: no command completes
        host_i.start_frame(1'b0);
        b = 8'(rnd());
        opq.push_back(b);
        host_i.xfer(b, r);
        host_i.xfer(8'h00, r);
        rst_n_in <= 1'b0;
        repeat (6) @(posedge clk_in);
        rst_n_in <= 1'b1;
        host_i.end_frame(1'b0);
        chk("abort_idle", 24'h1, 24'(standby_out));
        // Reset pin during a running program
        fork
            frame(0, 2'd1, 1'b0, 1'b0);
            begin
                wait (busy_out === 1'b1);
                @(posedge clk_in);
                rst_n_in <= 1'b0;
                repeat (5) @(posedge clk_in);
                chk("busy_abort", 24'h0, 24'(busy_out));
                rst_n_in <= 1'b1;
            end
        join
        repeat (10) @(posedge clk_in);
        chk("notes_left", 24'h0, 24'(opq.size() + evq.size()));
        finish_test();
    end
endmodule : tb_sfpi_top
